// ===== hdl/spe_core.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module spe_core (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic step_pulse_in,
   input wire logic limit_switch_in,
   output logic step_out,
   output logic dir_out,
   output logic bridge_en,
   output spe_pkg::spe_mstate_t motion_state,
   output logic step_clock_mode_flag
);
   logic [11:0] accel_rate_r;
   logic [11:0] decel_rate_r;
   logic [11:0] floor_speed_r;
   logic [9:0] top_speed_r;
   logic [21:0] arg_r;
   logic swact_r;
   logic [2:0] ssel_r;
   logic [21:0] pos_r;
   logic [21:0] saved_r;
   logic [31:0] spd_r;
   logic [31:0] tgt_r;
   logic [21:0] rem_r;
   logic dir_r;
   logic float_r;
   logic save_r;
   logic bridge_r;
   spe_pkg::spe_mode_t mode_r;
   spe_pkg::spe_mstate_t mst_r;
   logic sck_r;
   logic [2:0] tick_cnt_r;
   logic [39:0] phase_r;
   logic step_r;
   logic [31:0] rdata_r;
   logic [2:0] step_pulse_in_sync_r;
   logic [2:0] sw_sync_r;

   logic tick;
   logic cmd_wr;
   spe_pkg::spe_cmdw_t cmdw;
   logic [31:0] floor_spd;
   logic [31:0] top_spd;
   logic [31:0] arg_spd;
   logic [31:0] run_tgt;
   logic [31:0] rel_spd;
   logic [21:0] pos_tgt;
   logic [21:0] diff;
   logic [21:0] diff_neg;
   logic moving;
   logic [40:0] phase_sum;
   logic step_evt;
   logic step_pulse_in_rise;
   logic sw_fall;
   logic sw_rise;
   logic sw_hit;
   logic [79:0] brake_lhs;
   logic [79:0] brake_rhs;
   logic brake_req;
   logic [31:0] spd_up;
   logic [31:0] spd_dn;

   assign tick = (tick_cnt_r == spe_pkg::TICK_LAST);
   assign cmd_wr = reg_wr && (reg_addr == spe_pkg::A_CMD);
   assign cmdw = spe_pkg::spe_cmdw_t'(reg_wdata[5:0]);

   // speeds scaled to the common 2^-40 step/tick unit
   assign floor_spd = 32'(floor_speed_r) << spe_pkg::FLOOR_SH;
   assign top_spd = 32'(top_speed_r) << spe_pkg::TOP_SH;
   assign arg_spd = 32'(arg_r[19:0]) << spe_pkg::ARG_SH;
   assign run_tgt = (arg_spd > top_spd) ? top_spd : arg_spd;
   assign rel_spd = (floor_spd < spe_pkg::REL_MIN_SPD) ? spe_pkg::REL_MIN_SPD
                                                        : floor_spd;

   always_comb begin
      case (cmdw.code)
         spe_pkg::C_ORIGIN: pos_tgt = 22'h00_0000;
         spe_pkg::C_SAVED: pos_tgt = saved_r;
         default: pos_tgt = arg_r;
      endcase
   end
   assign diff = pos_tgt - pos_r;
   assign diff_neg = 22'h00_0000 - diff;

   // two flip-flops from the pins, third stage only for edge detection
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         step_pulse_in_sync_r <= 3'h0;
         sw_sync_r <= 3'h7;
      end else begin
         step_pulse_in_sync_r <= {step_pulse_in_sync_r[1:0], step_pulse_in};
         sw_sync_r <= {sw_sync_r[1:0], limit_switch_in};
      end
   end
   assign step_pulse_in_rise = step_pulse_in_sync_r[1] && !step_pulse_in_sync_r[2];
   assign sw_fall = !sw_sync_r[1] && sw_sync_r[2];
   assign sw_rise = sw_sync_r[1] && !sw_sync_r[2];
   // a fresh command in the same cycle takes precedence over the switch
   assign sw_hit = !cmd_wr && (((mode_r == spe_pkg::M_UNTIL) && sw_fall) ||
                               ((mode_r == spe_pkg::M_REL) && sw_rise));

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tick_cnt_r <= 3'h0;
      end else if (tick) begin
         tick_cnt_r <= 3'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 3'h1;
      end
   end

   assign moving = (mode_r != spe_pkg::M_IDLE) && (mode_r != spe_pkg::M_SCK);
   assign phase_sum = {1'b0, phase_r} + ({9'h000, spd_r} << ssel_r);
   assign step_evt = (tick && moving && phase_sum[40]) ||
                     ((mode_r == spe_pkg::M_SCK) && step_pulse_in_rise);

   // remaining microsteps versus braking distance at the current speed
   // products widened first so neither side loses its top bits
   assign brake_lhs = (80'(spd_r) * 80'(spd_r)) << ssel_r;
   assign brake_rhs = (80'(decel_rate_r) * 80'(rem_r)) << 41;
   assign brake_req = (mode_r == spe_pkg::M_POS) && (brake_lhs >= brake_rhs);
   assign spd_up = (tgt_r - spd_r > 32'(accel_rate_r)) ? spd_r + 32'(accel_rate_r) : tgt_r;

   always_comb begin
      if (brake_req || (mode_r == spe_pkg::M_STOP)) begin
         spd_dn = (spd_r > floor_spd + 32'(decel_rate_r)) ? spd_r - 32'(decel_rate_r)
                                                          : floor_spd;
      end else begin
         spd_dn = (spd_r > tgt_r + 32'(decel_rate_r)) ? spd_r - 32'(decel_rate_r) : tgt_r;
      end
   end

   // software register file
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         accel_rate_r <= spe_pkg::ACCEL_RST;
         decel_rate_r <= spe_pkg::DECEL_RST;
         floor_speed_r <= spe_pkg::FLOOR_RST;
         top_speed_r <= spe_pkg::TOP_RST;
         arg_r <= 22'h00_0000;
         swact_r <= 1'b0;
         ssel_r <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            spe_pkg::A_ACCEL: begin
               accel_rate_r <= (reg_wdata[11:0] > spe_pkg::RATE_MAX) ? spe_pkg::RATE_MAX
                                                                     : reg_wdata[11:0];
            end
            spe_pkg::A_DECEL: begin
               decel_rate_r <= (reg_wdata[11:0] > spe_pkg::RATE_MAX) ? spe_pkg::RATE_MAX
                                                                     : reg_wdata[11:0];
            end
            spe_pkg::A_FLOOR: floor_speed_r <= reg_wdata[11:0];
            spe_pkg::A_TOP: begin
               top_speed_r <= (reg_wdata[9:0] < spe_pkg::TOP_MIN) ? spe_pkg::TOP_MIN
                                                                  : reg_wdata[9:0];
            end
            spe_pkg::A_ARG: arg_r <= reg_wdata[21:0];
            spe_pkg::A_CFG: begin
               swact_r <= reg_wdata[spe_pkg::CFG_SWACT];
               ssel_r <= (reg_wdata[spe_pkg::CFG_SSEL +: 3] > spe_pkg::SSEL_MAX)
                         ? spe_pkg::SSEL_MAX : reg_wdata[spe_pkg::CFG_SSEL +: 3];
            end
            default: ;
         endcase
      end
   end

   // position counter and saved point
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pos_r <= 22'h00_0000;
         saved_r <= 22'h00_0000;
      end else begin
         if (reg_wr && (reg_addr == spe_pkg::A_SAVED)) begin
            saved_r <= reg_wdata[21:0];
         end else if (sw_hit && save_r) begin
            saved_r <= pos_r;
         end
         if (reg_wr && (reg_addr == spe_pkg::A_POS)) begin
            pos_r <= reg_wdata[21:0];
         end else if (sw_hit && !save_r) begin
            pos_r <= 22'h00_0000;
         end else if (step_evt) begin
            pos_r <= dir_r ? pos_r + 22'h00_0001 : pos_r - 22'h00_0001;
         end
      end
   end

   // motion sequencer: commands, switch events and per-tick profile
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode_r <= spe_pkg::M_IDLE;
         mst_r <= spe_pkg::MS_STOPPED;
         spd_r <= 32'h0000_0000;
         tgt_r <= 32'h0000_0000;
         rem_r <= 22'h00_0000;
         dir_r <= 1'b1;
         float_r <= 1'b0;
         save_r <= 1'b0;
         bridge_r <= 1'b0;
         sck_r <= 1'b0;
      end else if (cmd_wr) begin
         // any command, stops included, is accepted mid-motion
         sck_r <= 1'b0;
         save_r <= cmdw.save;
         case (cmdw.code)
            spe_pkg::C_RUN, spe_pkg::C_UNTIL: begin
               mode_r <= (cmdw.code == spe_pkg::C_RUN) ? spe_pkg::M_RUN : spe_pkg::M_UNTIL;
               tgt_r <= run_tgt;
               dir_r <= cmdw.dir;
               bridge_r <= 1'b1;
               if (!moving) begin
                  spd_r <= floor_spd;
               end
            end
            spe_pkg::C_GO_TO_POSITION, spe_pkg::C_GO_TO_POSITION_DIRECTED, spe_pkg::C_ORIGIN, spe_pkg::C_SAVED: begin
               mode_r <= spe_pkg::M_POS;
               tgt_r <= top_spd;
               bridge_r <= 1'b1;
               if (!moving) begin
                  spd_r <= floor_spd;
               end
               if (cmdw.code == spe_pkg::C_GO_TO_POSITION_DIRECTED) begin
                  dir_r <= cmdw.dir;
                  rem_r <= cmdw.dir ? diff : diff_neg;
               end else begin
                  dir_r <= !diff[21];
                  rem_r <= diff[21] ? diff_neg : diff;
               end
            end
            spe_pkg::C_MOVE: begin
               mode_r <= spe_pkg::M_POS;
               tgt_r <= top_spd;
               rem_r <= arg_r;
               dir_r <= cmdw.dir;
               bridge_r <= 1'b1;
               if (!moving) begin
                  spd_r <= floor_spd;
               end
            end
            spe_pkg::C_RELEASE: begin
               mode_r <= spe_pkg::M_REL;
               spd_r <= rel_spd;
               tgt_r <= rel_spd;
               dir_r <= cmdw.dir;
               bridge_r <= 1'b1;
            end
            spe_pkg::C_DSTOP, spe_pkg::C_DFLOAT: begin
               float_r <= (cmdw.code == spe_pkg::C_DFLOAT);
               bridge_r <= 1'b1;
               if (moving) begin
                  mode_r <= spe_pkg::M_STOP;
                  mst_r <= spe_pkg::MS_DECEL;
               end else begin
                  bridge_r <= (cmdw.code == spe_pkg::C_DSTOP);
               end
            end
            spe_pkg::C_ISTOP, spe_pkg::C_IFLOAT: begin
               mode_r <= spe_pkg::M_IDLE;
               mst_r <= spe_pkg::MS_STOPPED;
               spd_r <= 32'h0000_0000;
               bridge_r <= (cmdw.code == spe_pkg::C_ISTOP);
            end
            spe_pkg::C_STEPCLK: begin
               mode_r <= spe_pkg::M_SCK;
               mst_r <= spe_pkg::MS_STOPPED;
               spd_r <= 32'h0000_0000;
               sck_r <= 1'b1;
               dir_r <= cmdw.dir;
               bridge_r <= 1'b1;
            end
            spe_pkg::C_NOP: begin
               if (mode_r == spe_pkg::M_SCK) begin
                  mode_r <= spe_pkg::M_IDLE;
               end
            end
            default: ;
         endcase
      end else if (sw_hit) begin
         if ((mode_r == spe_pkg::M_REL) || swact_r) begin
            mode_r <= spe_pkg::M_IDLE;
            mst_r <= spe_pkg::MS_STOPPED;
            spd_r <= 32'h0000_0000;
         end else begin
            mode_r <= spe_pkg::M_STOP;
            float_r <= 1'b0;
         end
      end else if ((mode_r == spe_pkg::M_POS) && (rem_r == 22'h00_0000 ||
                   (step_evt && rem_r == 22'h00_0001))) begin
         mode_r <= spe_pkg::M_IDLE;
         mst_r <= spe_pkg::MS_STOPPED;
         spd_r <= 32'h0000_0000;
         rem_r <= 22'h00_0000;
      end else begin
         if (step_evt && (mode_r == spe_pkg::M_POS)) begin
            rem_r <= rem_r - 22'h00_0001;
         end
         if (tick && moving && (mode_r != spe_pkg::M_REL)) begin
            if ((mode_r == spe_pkg::M_STOP) && (spd_r <= floor_spd)) begin
               mode_r <= spe_pkg::M_IDLE;
               mst_r <= spe_pkg::MS_STOPPED;
               spd_r <= 32'h0000_0000;
               bridge_r <= !float_r;
            end else if (brake_req || (mode_r == spe_pkg::M_STOP) || (spd_r > tgt_r)) begin
               spd_r <= spd_dn;
               mst_r <= spe_pkg::MS_DECEL;
            end else if (spd_r < tgt_r) begin
               spd_r <= spd_up;
               mst_r <= spe_pkg::MS_ACCEL;
            end else begin
               mst_r <= spe_pkg::MS_CONST;
            end
         end else if (mode_r == spe_pkg::M_REL) begin
            mst_r <= spe_pkg::MS_CONST;
         end
      end
   end

   // step generator: phase accumulator in units of the selected step mode
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         phase_r <= 40'h00_0000_0000;
         step_r <= 1'b0;
      end else begin
         step_r <= step_evt;
         if (!moving) begin
            phase_r <= 40'h00_0000_0000;
         end else if (tick) begin
            phase_r <= phase_sum[39:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            spe_pkg::A_ACCEL: rdata_r <= {20'h0_0000, accel_rate_r};
            spe_pkg::A_DECEL: rdata_r <= {20'h0_0000, decel_rate_r};
            spe_pkg::A_FLOOR: rdata_r <= {20'h0_0000, floor_speed_r};
            spe_pkg::A_TOP: rdata_r <= {22'h00_0000, top_speed_r};
            spe_pkg::A_ARG: rdata_r <= {10'h000, arg_r};
            spe_pkg::A_CFG: rdata_r <= {28'h000_0000, ssel_r, swact_r};
            spe_pkg::A_STATUS: begin
               rdata_r <= {26'h000_0000, float_r, bridge_r, dir_r, sck_r, mst_r};
            end
            spe_pkg::A_POS: rdata_r <= {{10{pos_r[21]}}, pos_r};
            spe_pkg::A_SAVED: rdata_r <= {{10{saved_r[21]}}, saved_r};
            spe_pkg::A_SPEED: rdata_r <= {12'h000, spd_r[31:12]};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata = rdata_r;
   assign step_out = step_r;
   assign dir_out = dir_r;
   assign bridge_en = bridge_r;
   assign motion_state = mst_r;
   assign step_clock_mode_flag = sck_r;
endmodule : spe_core

// ===== hdl/spe_pkg.sv
package spe_pkg;
   localparam logic [7:0] A_ACCEL = 8'h00;
   localparam logic [7:0] A_DECEL = 8'h04;
   localparam logic [7:0] A_FLOOR = 8'h08;
   localparam logic [7:0] A_TOP = 8'h0c;
   localparam logic [7:0] A_ARG = 8'h10;
   localparam logic [7:0] A_CMD = 8'h14;
   localparam logic [7:0] A_CFG = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1c;
   localparam logic [7:0] A_POS = 8'h20;
   localparam logic [7:0] A_SAVED = 8'h24;
   localparam logic [7:0] A_SPEED = 8'h28;
   localparam logic [11:0] ACCEL_RST = 12'h08a;
   localparam logic [11:0] DECEL_RST = 12'h08a;
   localparam logic [11:0] FLOOR_RST = 12'h000;
   localparam logic [9:0] TOP_RST = 10'h041;
   localparam logic [11:0] RATE_MAX = 12'hffe;
   localparam logic [9:0] TOP_MIN = 10'h001;
   localparam int CFG_SWACT = 0;
   localparam int CFG_SSEL = 1;
   localparam logic [2:0] SSEL_MAX = 3'h4;
   // internal speed unit is 2^-40 step/tick
   localparam int FLOOR_SH = 16;
   localparam int TOP_SH = 22;
   localparam int ARG_SH = 12;
   localparam int CLK_NS = 40;
   localparam int TICK_NS = 250;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);
   localparam longint REL_SPS = 5;
   localparam logic [31:0] REL_MIN_SPD =
      32'((REL_SPS * TICK_NS * (64'h1 << 40) + 999_999_999) / 1_000_000_000);
   typedef enum logic [3:0] {
      C_NOP = 4'b0000, C_RUN = 4'b0001, C_GO_TO_POSITION = 4'b0010, C_GO_TO_POSITION_DIRECTED = 4'b0011,
      C_ORIGIN = 4'b0100, C_SAVED = 4'b0101, C_MOVE = 4'b0110, C_UNTIL = 4'b0111,
      C_RELEASE = 4'b1000, C_DSTOP = 4'b1001, C_ISTOP = 4'b1010,
      C_DFLOAT = 4'b1011, C_IFLOAT = 4'b1100, C_STEPCLK = 4'b1101
   } spe_cmd_t;
   typedef enum logic [1:0] {
      MS_STOPPED = 2'b00, MS_ACCEL = 2'b01, MS_DECEL = 2'b10, MS_CONST = 2'b11
   } spe_mstate_t;
   typedef enum logic [2:0] {
      M_IDLE = 3'b000, M_RUN = 3'b001, M_POS = 3'b010, M_UNTIL = 3'b011,
      M_REL = 3'b100, M_STOP = 3'b101, M_SCK = 3'b110
   } spe_mode_t;
   // command word: save flag (0 clears position), direction (1 forward), code
   typedef struct packed {
      logic save;
      logic dir;
      spe_cmd_t code;
   } spe_cmdw_t;
endpackage : spe_pkg

// ===== tb/spe_core_monitor.sv
`timescale 1ns/1ps
module spe_core_monitor (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic step_pulse_in,
   input wire logic limit_switch_in,
   input wire logic step_out,
   input wire logic dir_out,
   input wire logic bridge_en,
   input wire spe_pkg::spe_mstate_t motion_state,
   input wire logic step_clock_mode_flag
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence s_cmd(logic [3:0] c);
      reg_wr && reg_addr == spe_pkg::A_CMD && reg_wdata[3:0] == c;
   endsequence
   sequence s_held_quiet;
      (bridge_en && motion_state == spe_pkg::MS_STOPPED && !step_out) [*4];
   endsequence
   chk_sck_stopped: assert property (step_clock_mode_flag |-> motion_state == spe_pkg::MS_STOPPED)
      else $error("motion reported while in step-clock mode");
   chk_sck_enter: assert property (s_cmd(spe_pkg::C_STEPCLK) |=> step_clock_mode_flag)
      else $error("step-clock flag not raised");
   chk_sck_pulse: assert property (step_clock_mode_flag && $rose(step_pulse_in) |-> ##[2:5] step_out)
      else $error("step pulse did not produce a microstep");
   chk_istop_hold: assert property (s_cmd(spe_pkg::C_ISTOP) |=> ##1 s_held_quiet)
      else $error("immediate stop did not halt with bridges driven");
   chk_ifloat_off: assert property (s_cmd(spe_pkg::C_IFLOAT) |=>
      !bridge_en && motion_state == spe_pkg::MS_STOPPED)
      else $error("immediate float left bridges driven");
   chk_dstop_noacc: assert property (s_cmd(spe_pkg::C_DSTOP) |=>
      bridge_en && motion_state != spe_pkg::MS_ACCEL)
      else $error("decel stop kept accelerating");
   chk_float_nostep: assert property (!bridge_en && !step_clock_mode_flag |-> !step_out)
      else $error("step taken with bridges floating");
   // the top speed limit stays below one step per tick, so steps are 6 clocks apart at least
   chk_step_space: assert property (step_out && !step_clock_mode_flag |=> !step_out [*5])
      else $error("steps closer than one tick");
   chk_status_read: assert property (reg_rd && reg_addr == spe_pkg::A_STATUS |=>
      reg_rdata[2:0] == {$past(step_clock_mode_flag), $past(motion_state)})
      else $error("status read does not match outputs");
   chk_unmapped_read: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : spe_core_monitor
bind spe_core spe_core_monitor spe_core_monitor_inst (.clk_sys(clk_sys), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .step_pulse_in(step_pulse_in), .limit_switch_in(limit_switch_in),
   .step_out(step_out), .dir_out(dir_out), .bridge_en(bridge_en),
   .motion_state(motion_state), .step_clock_mode_flag(step_clock_mode_flag));

// ===== tb/spe_fixture.sv
`timescale 1ns/1ps
module spe_fixture (
   input wire logic clk_sys,
   output logic step_pulse_in,
   output logic limit_switch_in
);
   initial begin
      step_pulse_in = 1'b0;
      // switch open reads high through the pull-up
      limit_switch_in = 1'b1;
   end
   // pulses held 5 clocks each way so the two-stage synchroniser never misses one
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         step_pulse_in <= 1'b1;
         repeat (5) @(posedge clk_sys);
         step_pulse_in <= 1'b0;
         repeat (5) @(posedge clk_sys);
      end
   endtask : pulse
   task automatic switch_after(input int dly, input logic lvl);
      repeat (dly) @(posedge clk_sys);
      limit_switch_in <= lvl;
   endtask : switch_after
endmodule : spe_fixture

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [31:0] v; logic [31:0] m;} spe_exp_t;
   logic clk_sys, rst_b, reg_wr, reg_rd, rd_d, step_out, dir_out, bridge_en, sck_flag;
   logic step_pulse_in, limit_switch_in;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rnd;
   spe_pkg::spe_mstate_t motion_state;
   spe_exp_t exp_q[$];
   spe_exp_t e;
   int n_errors = 0;
   int n_compared = 0;
   spe_pkg::spe_cmd_t stops[4] = '{spe_pkg::C_DSTOP, spe_pkg::C_ISTOP,
      spe_pkg::C_DFLOAT, spe_pkg::C_IFLOAT};
   spe_core spe_core_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .step_pulse_in(step_pulse_in), .limit_switch_in(limit_switch_in), .step_out(step_out),
      .dir_out(dir_out), .bridge_en(bridge_en), .motion_state(motion_state),
      .step_clock_mode_flag(sck_flag));
   spe_fixture spe_fixture_inst (.clk_sys(clk_sys), .step_pulse_in(step_pulse_in),
      .limit_switch_in(limit_switch_in));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic report_and_stop;
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] v,
      input logic [31:0] m = 32'hffff_ffff);
      exp_q.push_back('{v, m});
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic cmd(input spe_pkg::spe_cmd_t c, input logic d, input logic s,
      input logic [31:0] arg);
      wr(spe_pkg::A_ARG, arg);
      wr(spe_pkg::A_CMD, {26'h000_0000, s, d, c});
   endtask : cmd
   task automatic wait_stop(input int lim);
      int k = 0;
      repeat (8) @(posedge clk_sys);
      while (motion_state !== spe_pkg::MS_STOPPED && k < lim) begin
         @(posedge clk_sys);
         k++;
      end
      check({30'h0000_0000, motion_state}, 32'h0000_0000);
   endtask : wait_stop
   // read data appear in the cycle after the strobe and hold until the next read
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         e = exp_q.pop_front();
         check(reg_rdata & e.m, e.v & e.m);
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_d = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      rnd = $urandom(58);
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(spe_pkg::A_ACCEL, 32'h0000_008a);
      rd(spe_pkg::A_DECEL, 32'h0000_008a);
      rd(spe_pkg::A_FLOOR, 32'h0000_0000);
      rd(spe_pkg::A_TOP, 32'h0000_0041);
      rd(spe_pkg::A_STATUS, 32'h0000_0008);
      rd(8'h30, 32'h0000_0000);
      wr(spe_pkg::A_ACCEL, 32'h0000_0fff);
      rd(spe_pkg::A_ACCEL, 32'h0000_0ffe);
      wr(spe_pkg::A_TOP, 32'h0000_0000);
      rd(spe_pkg::A_TOP, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom % 32'h0000_0fff;
         wr(spe_pkg::A_DECEL, rnd);
         rd(spe_pkg::A_DECEL, rnd);
         wr(spe_pkg::A_FLOOR, rnd + 1);
         rd(spe_pkg::A_FLOOR, rnd + 1);
      end
      wr(spe_pkg::A_CFG, 32'h0000_0008);
      wr(spe_pkg::A_FLOOR, 32'h0000_0fff);
      wr(spe_pkg::A_TOP, 32'h0000_03ff);
      wr(spe_pkg::A_DECEL, 32'h0000_0ffe);
      wr(spe_pkg::A_POS, 32'h001f_ffff);
      rd(spe_pkg::A_POS, 32'h001f_ffff);
      wr(spe_pkg::A_POS, 32'h0020_0000);
      rd(spe_pkg::A_POS, 32'hffe0_0000);
      // a forward move across the top of the range must wrap to the negative end
      wr(spe_pkg::A_POS, 32'h001f_fffe);
      cmd(spe_pkg::C_MOVE, 1'b1, 1'b0, 32'h0000_0003);
      wait_stop(20000);
      rd(spe_pkg::A_POS, 32'hffe0_0001);
      wr(spe_pkg::A_POS, 32'h0000_0000);
      cmd(spe_pkg::C_GO_TO_POSITION, 1'b1, 1'b0, 32'h0000_0002);
      wait_stop(20000);
      rd(spe_pkg::A_POS, 32'h0000_0002);
      cmd(spe_pkg::C_ORIGIN, 1'b1, 1'b0, 32'h0000_0000);
      wait_stop(20000);
      rd(spe_pkg::A_POS, 32'h0000_0000);
      rd(spe_pkg::A_STATUS, 32'h0000_0000, 32'h0000_0008);
      wr(spe_pkg::A_SAVED, 32'h0000_0001);
      cmd(spe_pkg::C_SAVED, 1'b1, 1'b0, 32'h0000_0000);
      wait_stop(20000);
      rd(spe_pkg::A_POS, 32'h0000_0001);
      cmd(spe_pkg::C_GO_TO_POSITION_DIRECTED, 1'b0, 1'b0, 32'h0000_0000);
      wait_stop(20000);
      rd(spe_pkg::A_POS, 32'h0000_0000);
      foreach (stops[i]) begin
         cmd(spe_pkg::C_RUN, 1'b1, 1'b0, 32'h0001_0000);
         repeat (30) @(posedge clk_sys);
         rd(spe_pkg::A_STATUS, 32'h0000_0001, 32'h0000_0003);
         cmd(stops[i], 1'b1, 1'b0, 32'h0000_0000);
         wait_stop(5000);
         rd(spe_pkg::A_STATUS, (i < 2) ? 32'h0000_0018 : 32'h0000_0008,
            32'h0000_001f);
      end
      wr(spe_pkg::A_POS, 32'h0000_0000);
      cmd(spe_pkg::C_STEPCLK, 1'b1, 1'b0, 32'h0000_0000);
      spe_fixture_inst.pulse(5);
      repeat (10) @(posedge clk_sys);
      rd(spe_pkg::A_POS, 32'h0000_0005);
      rd(spe_pkg::A_STATUS, 32'h0000_0004, 32'h0000_0007);
      rd(spe_pkg::A_SPEED, 32'h0000_0000);
      cmd(spe_pkg::C_NOP, 1'b1, 1'b0, 32'h0000_0000);
      wr(spe_pkg::A_CFG, 32'h0000_0009);
      wr(spe_pkg::A_POS, 32'h0000_0123);
      cmd(spe_pkg::C_UNTIL, 1'b1, 1'b0, 32'h0001_0000);
      spe_fixture_inst.switch_after(200, 1'b0);
      wait_stop(20);
      rd(spe_pkg::A_POS, 32'h0000_0000);
      rd(spe_pkg::A_STATUS, 32'h0000_0018, 32'h0000_001f);
      wr(spe_pkg::A_SAVED, ($urandom & 32'h001f_ffff) | 32'h0000_0001);
      wr(spe_pkg::A_POS, 32'h0000_0000);
      cmd(spe_pkg::C_RELEASE, 1'b1, 1'b1, 32'h0000_0000);
      spe_fixture_inst.switch_after(100, 1'b1);
      wait_stop(20);
      rd(spe_pkg::A_SAVED, 32'h0000_0000);
      rd(spe_pkg::A_STATUS, 32'h0000_0018, 32'h0000_001f);
      repeat (4) @(posedge clk_sys);
      report_and_stop();
   end
endmodule : tb_top
